// >>> ocd_decoder.sv
/*
  Partial opcode decoder with a classic Wishbone register slave.
  Software writes opcode bytes one at a time into CTRL; the decoder
  reports class, width, field use and trailing byte count in INFO.
  Assumes a single synchronous Wishbone master on CLK.
*/
`timescale 1ns/100ps
module ocd_decoder (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O
);

  logic ack_ff;
  logic [31:0] rdat_ff;
  logic [7:0] op1_ff;
  logic [7:0] op2_ff;
  logic iter_ff;
  logic iter_z_ff;
  ocd_pkg::ocd_state_t st_ff;
  ocd_pkg::ocd_state_t nxt_st;
  ocd_pkg::ocd_class_t cls_ff;
  ocd_pkg::ocd_class_t nxt_cls;
  ocd_pkg::ocd_field_t fld_ff;
  ocd_pkg::ocd_field_t nxt_fld;
  logic [2:0] nimm_ff;
  logic [2:0] nxt_nimm;
  logic [3:0] cond_ff;
  logic wide_ff;
  logic regdst_ff;
  logic cnt_reg_ff;
  logic zbit_ff;

  wire req = WB_CYC_I && WB_STB_I && !ack_ff;
  wire hit_ctrl = WB_ADR_I == ocd_pkg::OFS_CTRL;
  wire hit_stat = WB_ADR_I == ocd_pkg::OFS_STAT;
  wire hit_info = WB_ADR_I == ocd_pkg::OFS_INFO;
  wire hit_opnd = WB_ADR_I == ocd_pkg::OFS_OPND;
  wire byte_wr = req && WB_WE_I && hit_ctrl && WB_SEL_I[0];
  wire [7:0] wbyte = WB_DAT_I[7:0];
  wire clr_wr = byte_wr && WB_DAT_I[8];

  // Byte under decode: always the first byte, from the bus outside NEED2 and from op1_ff in NEED2
  wire [7:0] b1 = (st_ff == ocd_pkg::OCD_NEED2) ? op1_ff : wbyte;
  wire [2:0] mid = wbyte[5:3];
  wire wbit = b1[0];
  wire [7:0] bw = b1 & ocd_pkg::MSK_W;
  wire [7:0] bdw = b1 & ocd_pkg::MSK_DW;
  wire is_f6 = bw == ocd_pkg::OP_GRP_F6;
  wire is_sh = bdw == ocd_pkg::OP_GRP_SH;
  wire is_bcd = b1 == ocd_pkg::OP_BCD_PROD || b1 == ocd_pkg::OP_BCD_QUOT;
  wire needs2 = is_f6 || is_sh || is_bcd || b1 == ocd_pkg::OP_GRP_FF ||
                bdw == ocd_pkg::OP_AND_RM || bdw == ocd_pkg::OP_OR_RM ||
                bdw == ocd_pkg::OP_XOR_RM || bw == ocd_pkg::OP_TST_RM;
  wire [2:0] imm_w = wbit ? ocd_pkg::N_IMM2 : ocd_pkg::N_IMM1;

  // First-byte-only classes
  ocd_pkg::ocd_class_t c1;
  ocd_pkg::ocd_field_t f1;
  logic [2:0] n1;
  always_comb begin
    c1 = ocd_pkg::OCD_ILLEGAL;
    f1 = ocd_pkg::OCD_F_NONE;
    n1 = ocd_pkg::N_IMM0;
    if ((b1 & ocd_pkg::MSK_CC4) == ocd_pkg::OP_JCC_BASE) begin
      c1 = ocd_pkg::OCD_JCC;
      f1 = ocd_pkg::OCD_F_DISP;
      n1 = ocd_pkg::N_IMM1;
    end else if (bdw == ocd_pkg::OP_LOOP_BASE) begin
      f1 = ocd_pkg::OCD_F_DISP;
      n1 = ocd_pkg::N_IMM1;
      case (b1[1:0])
        2'h0: c1 = ocd_pkg::OCD_LOOP_NZ;
        2'h1: c1 = ocd_pkg::OCD_LOOP_Z;
        2'h2: c1 = ocd_pkg::OCD_LOOP;
        default: c1 = ocd_pkg::OCD_CNTZ_BR;
      endcase
    end else if (bw == ocd_pkg::OP_AND_AI || bw == ocd_pkg::OP_OR_AI ||
                 bw == ocd_pkg::OP_XOR_AI || bw == ocd_pkg::OP_TST_AI) begin
      f1 = ocd_pkg::OCD_F_ACC;
      n1 = imm_w;
      if (bw == ocd_pkg::OP_AND_AI) c1 = ocd_pkg::OCD_AND;
      else if (bw == ocd_pkg::OP_OR_AI) c1 = ocd_pkg::OCD_OR;
      else if (bw == ocd_pkg::OP_XOR_AI) c1 = ocd_pkg::OCD_XOR;
      else c1 = ocd_pkg::OCD_TEST;
    end else if (bw == ocd_pkg::OP_ITER) begin
      c1 = ocd_pkg::OCD_ITER;
    end else if (bw == ocd_pkg::OP_SCOPY) begin
      c1 = ocd_pkg::OCD_SCOPY;
    end else if (bw == ocd_pkg::OP_SCMP) begin
      c1 = ocd_pkg::OCD_SCMP;
    end else if (bw == ocd_pkg::OP_SSCAN) begin
      c1 = ocd_pkg::OCD_SSCAN;
    end else if (bw == ocd_pkg::OP_SLOAD) begin
      c1 = ocd_pkg::OCD_SLOAD;
      f1 = ocd_pkg::OCD_F_ACC;
    end else if (bw == ocd_pkg::OP_SSTORE) begin
      c1 = ocd_pkg::OCD_SSTORE;
      f1 = ocd_pkg::OCD_F_ACC;
    end else begin
      case (b1)
        ocd_pkg::OP_B2W: c1 = ocd_pkg::OCD_B2W;
        ocd_pkg::OP_W2D: c1 = ocd_pkg::OCD_W2D;
        ocd_pkg::OP_ASC_SUB: c1 = ocd_pkg::OCD_ASUB;
        ocd_pkg::OP_DEC_SUB: c1 = ocd_pkg::OCD_DSUB;
        ocd_pkg::OP_TRAP_N: begin
          c1 = ocd_pkg::OCD_TRAPN;
          n1 = ocd_pkg::N_IMM1;
        end
        ocd_pkg::OP_TRAP_3: c1 = ocd_pkg::OCD_TRAP3;
        ocd_pkg::OP_TRAP_OV: c1 = ocd_pkg::OCD_TRAPOV;
        ocd_pkg::OP_TRAP_EXIT: c1 = ocd_pkg::OCD_TRAPX;
        ocd_pkg::OP_EXIT_N: c1 = ocd_pkg::OCD_EXIT_N;
        ocd_pkg::OP_EXIT_F: c1 = ocd_pkg::OCD_EXIT_F;
        ocd_pkg::OP_EXIT_NI: begin
          c1 = ocd_pkg::OCD_EXIT_N;
          n1 = ocd_pkg::N_IMM2;
        end
        ocd_pkg::OP_EXIT_FI: begin
          c1 = ocd_pkg::OCD_EXIT_F;
          n1 = ocd_pkg::N_IMM2;
        end
        ocd_pkg::OP_CALL_N: begin
          c1 = ocd_pkg::OCD_CALL_N;
          f1 = ocd_pkg::OCD_F_DISP;
          n1 = ocd_pkg::N_IMM2;
        end
        ocd_pkg::OP_UBR_N: begin
          c1 = ocd_pkg::OCD_UBR_N;
          f1 = ocd_pkg::OCD_F_DISP;
          n1 = ocd_pkg::N_IMM2;
        end
        ocd_pkg::OP_UBR_S: begin
          c1 = ocd_pkg::OCD_UBR_S;
          f1 = ocd_pkg::OCD_F_DISP;
          n1 = ocd_pkg::N_IMM1;
        end
        ocd_pkg::OP_CALL_F: begin
          c1 = ocd_pkg::OCD_CALL_F;
          n1 = ocd_pkg::N_IMM4;
        end
        ocd_pkg::OP_UBR_F: begin
          c1 = ocd_pkg::OCD_UBR_F;
          n1 = ocd_pkg::N_IMM4;
        end
        default: c1 = ocd_pkg::OCD_ILLEGAL;
      endcase
    end
  end

  // Two-byte classes; wbyte is the second byte here
  ocd_pkg::ocd_class_t c2;
  ocd_pkg::ocd_field_t f2;
  logic [2:0] n2;
  always_comb begin
    c2 = ocd_pkg::OCD_ILLEGAL;
    f2 = ocd_pkg::OCD_F_MODRM;
    n2 = ocd_pkg::N_IMM0;
    if (is_f6) begin
      case (mid)
        3'h0: begin
          c2 = ocd_pkg::OCD_TEST;
          n2 = imm_w;
        end
        3'h2: c2 = ocd_pkg::OCD_INVERT;
        3'h4: c2 = ocd_pkg::OCD_UPROD;
        3'h5: c2 = ocd_pkg::OCD_SPROD;
        3'h6: c2 = ocd_pkg::OCD_UQUOT;
        3'h7: c2 = ocd_pkg::OCD_SQUOT;
        default: c2 = ocd_pkg::OCD_ILLEGAL;
      endcase
    end else if (is_sh) begin
      case (mid)
        3'h0: c2 = ocd_pkg::OCD_LROT;
        3'h1: c2 = ocd_pkg::OCD_RROT;
        3'h2: c2 = ocd_pkg::OCD_CLROT;
        3'h3: c2 = ocd_pkg::OCD_CRROT;
        3'h4: c2 = ocd_pkg::OCD_LSH;
        3'h5: c2 = ocd_pkg::OCD_LRSH;
        3'h7: c2 = ocd_pkg::OCD_ARSH;
        default: c2 = ocd_pkg::OCD_ILLEGAL;
      endcase
    end else if (is_bcd) begin
      f2 = ocd_pkg::OCD_F_NONE;
      if (wbyte == ocd_pkg::OP_BCD_BASE) begin
        c2 = (b1 == ocd_pkg::OP_BCD_PROD) ? ocd_pkg::OCD_BCD_PROD :
             ocd_pkg::OCD_BCD_QUOT;
      end
    end else if (b1 == ocd_pkg::OP_GRP_FF) begin
      case (mid)
        3'h2: c2 = ocd_pkg::OCD_CALL_IN;
        3'h3: c2 = ocd_pkg::OCD_CALL_IF;
        3'h4: c2 = ocd_pkg::OCD_UBR_IN;
        3'h5: c2 = ocd_pkg::OCD_UBR_IF;
        default: c2 = ocd_pkg::OCD_ILLEGAL;
      endcase
    end else begin
      f2 = ocd_pkg::OCD_F_REGRM;
      if (bw == ocd_pkg::OP_TST_RM) c2 = ocd_pkg::OCD_TEST;
      else if (bdw == ocd_pkg::OP_AND_RM) c2 = ocd_pkg::OCD_AND;
      else if (bdw == ocd_pkg::OP_OR_RM) c2 = ocd_pkg::OCD_OR;
      else c2 = ocd_pkg::OCD_XOR;
    end
  end

  // Sequencer: idle takes a first byte, two-byte codes wait for more
  always_comb begin
    nxt_st = st_ff;
    nxt_cls = cls_ff;
    nxt_fld = fld_ff;
    nxt_nimm = nimm_ff;
    if (clr_wr) begin
      nxt_st = ocd_pkg::OCD_IDLE;
    end else if (byte_wr) begin
      case (st_ff)
        ocd_pkg::OCD_NEED2: begin
          nxt_st = ocd_pkg::OCD_DONE;
          nxt_cls = c2;
          nxt_fld = f2;
          nxt_nimm = n2;
        end
        default: begin
          if (needs2) begin
            nxt_st = ocd_pkg::OCD_NEED2;
            nxt_cls = ocd_pkg::OCD_NONE;
          end else begin
            nxt_st = ocd_pkg::OCD_DONE;
            nxt_cls = c1;
            nxt_fld = f1;
            nxt_nimm = n1;
          end
        end
      endcase
    end
  end

  wire first_wr = byte_wr && !clr_wr && st_ff != ocd_pkg::OCD_NEED2;
  wire done_wr = byte_wr && !clr_wr && nxt_st == ocd_pkg::OCD_DONE;

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      st_ff <= ocd_pkg::OCD_IDLE;
      cls_ff <= ocd_pkg::OCD_NONE;
      fld_ff <= ocd_pkg::OCD_F_NONE;
      nimm_ff <= ocd_pkg::N_IMM0;
      op1_ff <= 8'h00;
      op2_ff <= 8'h00;
    end else begin
      st_ff <= nxt_st;
      cls_ff <= nxt_cls;
      fld_ff <= nxt_fld;
      nimm_ff <= nxt_nimm;
      if (first_wr) op1_ff <= wbyte;
      if (byte_wr && st_ff == ocd_pkg::OCD_NEED2) op2_ff <= wbyte;
    end
  end

  // Operand attributes latched once the instruction completes
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      wide_ff <= 1'b0;
      regdst_ff <= 1'b0;
      cnt_reg_ff <= 1'b0;
      cond_ff <= 4'h0;
      zbit_ff <= 1'b0;
    end else if (done_wr) begin
      wide_ff <= wbit;
      regdst_ff <= b1[1] && f2 == ocd_pkg::OCD_F_REGRM &&
                   bw != ocd_pkg::OP_TST_RM && st_ff ==
                   ocd_pkg::OCD_NEED2;
      cnt_reg_ff <= is_sh && b1[1];
      cond_ff <= b1[3:0];
      zbit_ff <= iter_ff && iter_z_ff && (bw == ocd_pkg::OP_SCMP ||
                 bw == ocd_pkg::OP_SSCAN);
    end
  end

  // Repeat prefix stays armed only until the next completed instruction
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      iter_ff <= 1'b0;
      iter_z_ff <= 1'b0;
    end else if (clr_wr) begin
      iter_ff <= 1'b0;
    end else if (done_wr) begin
      iter_ff <= c1 == ocd_pkg::OCD_ITER && st_ff != ocd_pkg::OCD_NEED2;
      if (c1 == ocd_pkg::OCD_ITER) iter_z_ff <= wbit;
    end
  end

  // Fixed count of one unless the count low byte is chosen
  wire [4:0] sh_count = cnt_reg_ff ? 5'h00 : ocd_pkg::SH_ONE;

  wire [31:0] stat_word = {16'h0000, op2_ff, op1_ff[7:2],
                           iter_ff, st_ff == ocd_pkg::OCD_NEED2};
  wire [31:0] info_word = {14'h0000, cls_ff, 1'b0, fld_ff,
                           1'b0, nimm_ff, zbit_ff, regdst_ff,
                           wide_ff, cnt_reg_ff};
  wire [31:0] opnd_word = {ocd_pkg::ID_VALUE[15:0], 7'h00, sh_count,
                           cond_ff};
  wire [31:0] rd_mux = hit_stat ? stat_word :
                       hit_info ? info_word :
                       hit_opnd ? opnd_word : 32'h0000_0000;

  // One wait state: ack in the cycle after the request is seen
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      ack_ff <= 1'b0;
      rdat_ff <= 32'h0000_0000;
    end else begin
      ack_ff <= req;
      rdat_ff <= (req && !WB_WE_I) ? rd_mux : 32'h0000_0000;
    end
  end

  assign WB_ACK_O = ack_ff;
  assign WB_DAT_O = rdat_ff;

  unprod_a: assert property (@(posedge CLK) disable iff (!RST_B)
    (byte_wr && !clr_wr && st_ff == ocd_pkg::OCD_NEED2 && is_f6 &&
     mid == 3'h4) |=> cls_ff == ocd_pkg::OCD_UPROD && wide_ff == $past(wbit))
    else $error("unsigned product not decoded");

  sprod_a: assert property (@(posedge CLK) disable iff (!RST_B)
    (byte_wr && !clr_wr && st_ff == ocd_pkg::OCD_NEED2 && is_f6 &&
     mid == 3'h5) |=> cls_ff == ocd_pkg::OCD_SPROD)
    else $error("signed product not decoded");

  quot_a: assert property (@(posedge CLK) disable iff (!RST_B)
    (byte_wr && !clr_wr && st_ff == ocd_pkg::OCD_NEED2 && is_f6 &&
     mid[2:1] == 2'h3) |=> (cls_ff == ocd_pkg::OCD_SQUOT) == $past(mid[0]))
    else $error("quotient kind wrong");

  test_imm_a: assert property (@(posedge CLK) disable iff (!RST_B)
    (done_wr && cls_ff != nxt_cls && nxt_cls == ocd_pkg::OCD_TEST &&
     f2 == ocd_pkg::OCD_F_MODRM && st_ff == ocd_pkg::OCD_NEED2)
    |=> nimm_ff == (wide_ff ? ocd_pkg::N_IMM2 : ocd_pkg::N_IMM1))
    else $error("test immediate count wrong");

  jcc_a: assert property (@(posedge CLK) disable iff (!RST_B)
    (first_wr && (wbyte & ocd_pkg::MSK_CC4) == ocd_pkg::OP_JCC_BASE)
    |=> cls_ff == ocd_pkg::OCD_JCC && nimm_ff == ocd_pkg::N_IMM1 &&
        st_ff == ocd_pkg::OCD_DONE)
    else $error("conditional branch not decoded");

  exit_imm_a: assert property (@(posedge CLK) disable iff (!RST_B)
    (first_wr && wbyte == ocd_pkg::OP_EXIT_FI)
    |=> cls_ff == ocd_pkg::OCD_EXIT_F && nimm_ff == ocd_pkg::N_IMM2)
    else $error("far exit immediate wrong");

  shift_cnt_a: assert property (@(posedge CLK) disable iff (!RST_B)
    (done_wr && st_ff == ocd_pkg::OCD_NEED2 && is_sh && !b1[1])
    |=> sh_count == ocd_pkg::SH_ONE)
    else $error("shift count not one");

  bus_ack_a: assert property (@(posedge CLK) disable iff (!RST_B)
    req |=> WB_ACK_O ##1 !WB_ACK_O)
    else $error("ack not a one-cycle pulse");

endmodule

// >>> ocd_fetch_bfm.sv
/*
  Fetch-side model of the opcode decoder: plays the prefetch path as
  a classic Wishbone master, one transfer per call of xfer.
  Assumes the slave answers with a registered one-cycle ack.
*/
`timescale 1ns/100ps
module ocd_fetch_bfm (
  input wire logic clk,
  input wire logic ack,
  input wire logic [31:0] dat_i,
  output logic cyc,
  output logic stb,
  output logic we,
  output logic [7:0] adr,
  output logic [3:0] sel,
  output logic [31:0] dat
);
  initial begin
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    dat = 32'h0000_0000;
  end

  // Released address and data are inverted so a slave latching late sees junk
  task automatic xfer(input logic w, input logic [7:0] a,
      input logic [3:0] s, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    dat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    q = dat_i;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    adr <= ~a;
    sel <= 4'h0;
    dat <= ~d;
  endtask
endmodule

// >>> ocd_pkg.sv
/*
  Package for the partial opcode decoder: Wishbone register offsets,
  opcode patterns, operation classes and byte-count constants.
  Assumes a 32-bit classic Wishbone master and a 125 MHz clock.
*/
package ocd_pkg;

  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_INFO = 8'h08;
  localparam logic [7:0] OFS_OPND = 8'h0C;
  localparam logic [31:0] ID_VALUE = 32'h0000_0D0C; // Arbitrary value

  localparam logic [7:0] OP_GRP_F6 = 8'hF6; // 1111011w
  localparam logic [7:0] OP_GRP_SH = 8'hD0; // 110100vw
  localparam logic [7:0] OP_BCD_PROD = 8'hD4;
  localparam logic [7:0] OP_BCD_QUOT = 8'hD5;
  localparam logic [7:0] OP_BCD_BASE = 8'h0A;
  localparam logic [7:0] OP_B2W = 8'h98;
  localparam logic [7:0] OP_W2D = 8'h99;
  localparam logic [7:0] OP_ASC_SUB = 8'h3F;
  localparam logic [7:0] OP_DEC_SUB = 8'h2F;
  localparam logic [7:0] OP_AND_RM = 8'h20;
  localparam logic [7:0] OP_OR_RM = 8'h08;
  localparam logic [7:0] OP_XOR_RM = 8'h30;
  localparam logic [7:0] OP_AND_AI = 8'h24;
  localparam logic [7:0] OP_OR_AI = 8'h0C;
  localparam logic [7:0] OP_XOR_AI = 8'h34;
  localparam logic [7:0] OP_TST_RM = 8'h84;
  localparam logic [7:0] OP_TST_AI = 8'hA8;
  localparam logic [7:0] OP_ITER = 8'hF2;
  localparam logic [7:0] OP_SCOPY = 8'hA4;
  localparam logic [7:0] OP_SCMP = 8'hA6;
  localparam logic [7:0] OP_SSCAN = 8'hAE;
  localparam logic [7:0] OP_SLOAD = 8'hAC;
  localparam logic [7:0] OP_SSTORE = 8'hAA;
  localparam logic [7:0] OP_JCC_BASE = 8'h70; // 0111cccc
  localparam logic [7:0] OP_LOOP_BASE = 8'hE0; // 111000cc
  localparam logic [7:0] OP_TRAP_N = 8'hCD;
  localparam logic [7:0] OP_TRAP_3 = 8'hCC;
  localparam logic [7:0] OP_TRAP_OV = 8'hCE;
  localparam logic [7:0] OP_TRAP_EXIT = 8'hCF;
  localparam logic [7:0] OP_EXIT_N = 8'hC3;
  localparam logic [7:0] OP_EXIT_F = 8'hCB;
  localparam logic [7:0] OP_EXIT_NI = 8'hC2;
  localparam logic [7:0] OP_EXIT_FI = 8'hCA;
  localparam logic [7:0] OP_CALL_N = 8'hE8;
  localparam logic [7:0] OP_CALL_F = 8'h9A;
  localparam logic [7:0] OP_UBR_N = 8'hE9;
  localparam logic [7:0] OP_UBR_S = 8'hEB;
  localparam logic [7:0] OP_UBR_F = 8'hEA;
  localparam logic [7:0] OP_GRP_FF = 8'hFF;

  // Masks that drop w, dw or vw / cc low bits
  localparam logic [7:0] MSK_W = 8'hFE;
  localparam logic [7:0] MSK_DW = 8'hFC;
  localparam logic [7:0] MSK_CC4 = 8'hF0;

  typedef enum logic [5:0] {
    OCD_NONE, OCD_UPROD, OCD_SPROD, OCD_UQUOT, OCD_SQUOT,
    OCD_BCD_PROD, OCD_BCD_QUOT, OCD_B2W, OCD_W2D, OCD_ASUB, OCD_DSUB,
    OCD_INVERT, OCD_TEST, OCD_LSH, OCD_LRSH, OCD_ARSH, OCD_LROT, OCD_RROT,
    OCD_CLROT, OCD_CRROT, OCD_AND, OCD_OR, OCD_XOR, OCD_ITER, OCD_SCOPY,
    OCD_SCMP, OCD_SSCAN, OCD_SLOAD, OCD_SSTORE, OCD_JCC, OCD_LOOP,
    OCD_LOOP_Z, OCD_LOOP_NZ, OCD_CNTZ_BR, OCD_TRAPN, OCD_TRAP3, OCD_TRAPOV,
    OCD_TRAPX, OCD_EXIT_N, OCD_EXIT_F, OCD_CALL_N, OCD_CALL_F,
    OCD_CALL_IN, OCD_CALL_IF, OCD_UBR_N, OCD_UBR_S, OCD_UBR_F,
    OCD_UBR_IN, OCD_UBR_IF, OCD_ILLEGAL
  } ocd_class_t;

  // Operand-field meaning
  typedef enum logic [2:0] {
    OCD_F_NONE, OCD_F_MODRM, OCD_F_REGRM, OCD_F_ACC, OCD_F_DISP
  } ocd_field_t;

  typedef enum logic [1:0] {
    OCD_IDLE, OCD_NEED2, OCD_DONE
  } ocd_state_t;

  localparam logic [2:0] N_IMM0 = 3'h0;
  localparam logic [2:0] N_IMM1 = 3'h1;
  localparam logic [2:0] N_IMM2 = 3'h2;
  localparam logic [2:0] N_IMM4 = 3'h4;
  localparam logic [4:0] SH_ONE = 5'h01;

endpackage

// >>> tb_top.sv
/*
  Self-checking bench for the opcode decoder: a table of opcodes,
  then hand-written checks of fields, prefix, abort and reset.
  Assumes the decoder updates INFO at the ack edge of each byte.
*/
`timescale 1ns/100ps
`define CHK(nm, e, a) begin n_compared++; if ((a) !== (e)) begin \
  n_errors++; $display("wrong value %s expected %h seen %h", nm, e, a); \
  end end
module tb_top;
  logic CLK;
  logic RST_B;
  logic cyc, stb, we, ack;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, q;
  int n_errors;
  int n_compared;
  typedef struct {logic [7:0] b0; logic [7:0] b1;
    ocd_pkg::ocd_class_t c; logic [2:0] n; logic [1:0] w;} ocd_row_t;
  ocd_row_t rows[$];

  ocd_decoder uut (.CLK(CLK), .RST_B(RST_B), .WB_CYC_I(cyc),
    .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
    .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack));
  ocd_fetch_bfm bfm (.clk(CLK), .ack(ack), .dat_i(rdat), .cyc(cyc),
    .stb(stb), .we(we), .adr(adr), .sel(sel), .dat(wdat));

  initial begin
    CLK = 1'b0;
    forever #4 CLK = ~CLK;
  end

  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic put(input logic [7:0] b);
    bfm.xfer(1'b1, ocd_pkg::OFS_CTRL, 4'hF, {24'h0, b}, q);
  endtask
  task automatic get(input logic [7:0] a);
    bfm.xfer(1'b0, a, 4'hF, 32'h0, q);
  endtask
  // A second byte of 00 never occurs here, so it marks one-byte codes
  task automatic op(input logic [7:0] b0, input logic [7:0] b1);
    put(b0);
    if (b1 != 8'h00) put(b1);
    get(ocd_pkg::OFS_INFO);
  endtask
  task automatic r(input logic [7:0] b0, input logic [7:0] b1,
      input ocd_pkg::ocd_class_t c, input logic [2:0] n, input logic [1:0] w);
    rows.push_back('{b0, b1, c, n, w});
  endtask

  initial begin
    repeat (20000) @(posedge CLK);
    n_errors++;
    end_sim;
  end

  initial begin
    RST_B = 1'b0;
    n_errors = 0;
    n_compared = 0;
    r(8'hF6,8'hE0,ocd_pkg::OCD_UPROD,3'h0,2'h0);
    r(8'hF7,8'hE8,ocd_pkg::OCD_SPROD,3'h0,2'h1);
    r(8'hF6,8'hF0,ocd_pkg::OCD_UQUOT,3'h0,2'h0);
    r(8'hF7,8'hF8,ocd_pkg::OCD_SQUOT,3'h0,2'h1);
    r(8'hD4,8'h0A,ocd_pkg::OCD_BCD_PROD,3'h0,2'h2);
    r(8'hD5,8'h0A,ocd_pkg::OCD_BCD_QUOT,3'h0,2'h2);
    r(8'h98,8'h00,ocd_pkg::OCD_B2W,3'h0,2'h2);
    r(8'h99,8'h00,ocd_pkg::OCD_W2D,3'h0,2'h2);
    r(8'h3F,8'h00,ocd_pkg::OCD_ASUB,3'h0,2'h2);
    r(8'h2F,8'h00,ocd_pkg::OCD_DSUB,3'h0,2'h2);
    r(8'hF7,8'hD0,ocd_pkg::OCD_INVERT,3'h0,2'h1);
    r(8'hF6,8'hC0,ocd_pkg::OCD_TEST,3'h1,2'h0);
    r(8'hF7,8'hC0,ocd_pkg::OCD_TEST,3'h2,2'h1);
    r(8'hD0,8'hE0,ocd_pkg::OCD_LSH,3'h0,2'h0);
    r(8'hD1,8'hE8,ocd_pkg::OCD_LRSH,3'h0,2'h1);
    r(8'hD3,8'hF8,ocd_pkg::OCD_ARSH,3'h0,2'h1);
    r(8'hD0,8'hC0,ocd_pkg::OCD_LROT,3'h0,2'h0);
    r(8'hD1,8'hC8,ocd_pkg::OCD_RROT,3'h0,2'h1);
    r(8'hD2,8'hD0,ocd_pkg::OCD_CLROT,3'h0,2'h0);
    r(8'hD3,8'hD8,ocd_pkg::OCD_CRROT,3'h0,2'h1);
    r(8'h20,8'hC0,ocd_pkg::OCD_AND,3'h0,2'h0);
    r(8'h09,8'hC0,ocd_pkg::OCD_OR,3'h0,2'h1);
    r(8'h33,8'hC0,ocd_pkg::OCD_XOR,3'h0,2'h1);
    r(8'h24,8'h00,ocd_pkg::OCD_AND,3'h1,2'h0);
    r(8'h0D,8'h00,ocd_pkg::OCD_OR,3'h2,2'h1);
    r(8'h35,8'h00,ocd_pkg::OCD_XOR,3'h2,2'h1);
    r(8'h84,8'hC0,ocd_pkg::OCD_TEST,3'h0,2'h0);
    r(8'hA8,8'h00,ocd_pkg::OCD_TEST,3'h1,2'h0);
    r(8'hA9,8'h00,ocd_pkg::OCD_TEST,3'h2,2'h1);
    r(8'hA5,8'h00,ocd_pkg::OCD_SCOPY,3'h0,2'h1);
    r(8'hA6,8'h00,ocd_pkg::OCD_SCMP,3'h0,2'h0);
    r(8'hAF,8'h00,ocd_pkg::OCD_SSCAN,3'h0,2'h1);
    r(8'hAC,8'h00,ocd_pkg::OCD_SLOAD,3'h0,2'h0);
    r(8'hAB,8'h00,ocd_pkg::OCD_SSTORE,3'h0,2'h1);
    r(8'hE2,8'h00,ocd_pkg::OCD_LOOP,3'h1,2'h2);
    r(8'hE1,8'h00,ocd_pkg::OCD_LOOP_Z,3'h1,2'h2);
    r(8'hE0,8'h00,ocd_pkg::OCD_LOOP_NZ,3'h1,2'h2);
    r(8'hE3,8'h00,ocd_pkg::OCD_CNTZ_BR,3'h1,2'h2);
    r(8'hCD,8'h00,ocd_pkg::OCD_TRAPN,3'h1,2'h2);
    r(8'hCC,8'h00,ocd_pkg::OCD_TRAP3,3'h0,2'h2);
    r(8'hCE,8'h00,ocd_pkg::OCD_TRAPOV,3'h0,2'h2);
    r(8'hCF,8'h00,ocd_pkg::OCD_TRAPX,3'h0,2'h2);
    r(8'hC3,8'h00,ocd_pkg::OCD_EXIT_N,3'h0,2'h2);
    r(8'hCB,8'h00,ocd_pkg::OCD_EXIT_F,3'h0,2'h2);
    r(8'hC2,8'h00,ocd_pkg::OCD_EXIT_N,3'h2,2'h2);
    r(8'hCA,8'h00,ocd_pkg::OCD_EXIT_F,3'h2,2'h2);
    r(8'hE8,8'h00,ocd_pkg::OCD_CALL_N,3'h2,2'h2);
    r(8'h9A,8'h00,ocd_pkg::OCD_CALL_F,3'h4,2'h2);
    r(8'hE9,8'h00,ocd_pkg::OCD_UBR_N,3'h2,2'h2);
    r(8'hEB,8'h00,ocd_pkg::OCD_UBR_S,3'h1,2'h2);
    r(8'hEA,8'h00,ocd_pkg::OCD_UBR_F,3'h4,2'h2);
    r(8'hFF,8'hD0,ocd_pkg::OCD_CALL_IN,3'h0,2'h2);
    r(8'hFF,8'hD8,ocd_pkg::OCD_CALL_IF,3'h0,2'h2);
    r(8'hFF,8'hE0,ocd_pkg::OCD_UBR_IN,3'h0,2'h2);
    r(8'hFF,8'hE8,ocd_pkg::OCD_UBR_IF,3'h0,2'h2);
    repeat (16) @(posedge CLK);
    RST_B <= 1'b1;
    get(ocd_pkg::OFS_INFO);
    `CHK("info after reset", 32'h0, q)
    #1 `CHK("ack pulse", 1'b0, ack)
    `CHK("idle data", 32'h0, rdat)
    $display("test reset done");
    foreach (rows[i]) begin
      op(rows[i].b0, rows[i].b1);
      `CHK("class", rows[i].c, q[17:12])
      `CHK("count", rows[i].n, q[6:4])
      if (rows[i].w != 2'h2) `CHK("width", rows[i].w[0], q[1])
    end
    $display("test table done");
    for (int i = 0; i < 16; i++) begin
      op(8'h70 + i[7:0], 8'h00);
      `CHK("jcc class", ocd_pkg::OCD_JCC, q[17:12])
      `CHK("jcc count", 3'h1, q[6:4])
      `CHK("jcc field", ocd_pkg::OCD_F_DISP, q[10:8])
      get(ocd_pkg::OFS_OPND);
      `CHK("jcc cond", i[3:0], q[3:0])
    end
    $display("test branches done");
    op(8'hD1, 8'hE0);
    `CHK("count reg off", 1'b0, q[0])
    `CHK("modrm field", ocd_pkg::OCD_F_MODRM, q[10:8])
    get(ocd_pkg::OFS_OPND);
    `CHK("shift one", 5'h01, q[8:4])
    op(8'hD2, 8'hE0);
    `CHK("count reg on", 1'b1, q[0])
    get(ocd_pkg::OFS_OPND);
    `CHK("shift by reg", 5'h00, q[8:4])
    op(8'h22, 8'hC0);
    `CHK("to reg", 1'b1, q[2])
    `CHK("reg field", ocd_pkg::OCD_F_REGRM, q[10:8])
    op(8'h21, 8'hC0);
    `CHK("from reg", 1'b0, q[2])
    $display("test fields done");
    put(8'hF3);
    get(ocd_pkg::OFS_STAT);
    `CHK("armed", 1'b1, q[1])
    op(8'hA7, 8'h00);
    `CHK("iter cmp", ocd_pkg::OCD_SCMP, q[17:12])
    `CHK("iter zero set", 1'b1, q[3])
    op(8'hF2, 8'h00);
    `CHK("prefix", ocd_pkg::OCD_ITER, q[17:12])
    op(8'hAE, 8'h00);
    `CHK("iter zero clear", 1'b0, q[3])
    $display("test prefix done");
    put(8'hF7);
    get(ocd_pkg::OFS_STAT);
    `CHK("wait second", 1'b1, q[0])
    `CHK("first byte", 6'h3D, q[7:2])
    get(ocd_pkg::OFS_INFO);
    `CHK("none yet", ocd_pkg::OCD_NONE, q[17:12])
    bfm.xfer(1'b1, ocd_pkg::OFS_CTRL, 4'hF, 32'h0000_0100, q);
    get(ocd_pkg::OFS_STAT);
    `CHK("aborted", 1'b0, q[0])
    op(8'h98, 8'h00);
    bfm.xfer(1'b1, ocd_pkg::OFS_CTRL, 4'hE, 32'h0000_0099, q);
    bfm.xfer(1'b1, 8'h10, 4'hF, 32'h0000_0099, q);
    get(ocd_pkg::OFS_INFO);
    `CHK("sel ignored", ocd_pkg::OCD_B2W, q[17:12])
    get(8'h10);
    `CHK("unmapped", 32'h0, q)
    op(8'hD4, 8'h0B);
    `CHK("bad adjust", ocd_pkg::OCD_ILLEGAL, q[17:12])
    op(8'hF6, 8'hC8);
    `CHK("bad group", ocd_pkg::OCD_ILLEGAL, q[17:12])
    $display("test abort done");
    put(8'hF6);
    @(posedge CLK);
    RST_B <= 1'b0;
    @(posedge CLK);
    RST_B <= 1'b1;
    get(ocd_pkg::OFS_STAT);
    `CHK("stat reset", 32'h0, q)
    $display("test second reset done");
    end_sim;
  end
endmodule
